// >>> irq_arb_pkg.sv
// shared constants and types for the prioritized interrupt arbiter
`default_nettype none
package irq_arb_pkg;
	localparam int NUM_SRC = 18;
	localparam int ID_W    = 5;
	localparam int LVL_W   = 2;
	localparam int ADDR_W  = 8;
	localparam int VEC_W   = 16;

	// register byte offsets on the apb port
	localparam logic [ADDR_W-1:0] OFF_CTRL        = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ENABLE      = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_PENDING     = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_LSB_BASE    = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_LSB_FIRST   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_LSB_SECOND  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_MSB_BASE    = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_MSB_FIRST   = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_MSB_SECOND  = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h24;

	// field positions
	localparam int CTRL_GLOBAL_EN_BIT = 0;
	localparam int STAT_SVC_LSB       = 0;
	localparam int STAT_HOLD_BIT      = 4;
	localparam int STAT_STATE_LSB     = 8;
	localparam int STAT_ID_LSB        = 16;

	// reset values
	localparam logic        RST_GLOBAL_EN = 1'b0;
	localparam logic [17:0] RST_ENABLE    = 18'h00000;
	localparam logic [17:0] RST_PENDING   = 18'h00000;
	localparam logic [17:0] RST_PRIO      = 18'h00000;

	// timing counts in system clocks
	localparam int DETECT_CYCLES = 1;
	localparam int CALL_CYCLES   = 4;

	// handler entry addresses: base plus stride per source
	localparam logic [VEC_W-1:0] VEC_BASE   = 16'h0003;
	localparam logic [VEC_W-1:0] VEC_STRIDE = 16'h0008;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_DETECT = 2'b01,
		ST_CALL   = 2'b10
	} arb_state_t;

	typedef struct packed {
		logic             valid;
		logic [ID_W-1:0]  id;
		logic [LVL_W-1:0] level;
	} winner_t;
endpackage
`default_nettype wire

// >>> prio_select.sv
// per-source level decode and fixed-order winner selection
`timescale 1ns/100ps
`default_nettype none
module prio_select
	import irq_arb_pkg::*;
(
	input  wire logic [NUM_SRC-1:0] req,
	input  wire logic [NUM_SRC-1:0] prio_lsb,
	input  wire logic [NUM_SRC-1:0] prio_msb,
	input  wire logic               clk,
	input  wire logic               rst_n,
	output winner_t                 win
);
	logic [LVL_W-1:0] lvl [NUM_SRC];

	// level is msb:lsb, so 00 lowest and 11 highest
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : g_dec
			assign lvl[g] = {prio_msb[g], prio_lsb[g]};
		end
	endgenerate

	// scan from the top index down; >= lets the lower index win ties
	always_comb
	begin
		win = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (req[i] && (!win.valid || lvl[i] >= win.level))
			begin
				win.valid = 1'b1;
				win.id    = ID_W'(i);
				win.level = lvl[i];
			end
		end
	end

	// helper for checking: any request above the chosen level
	logic any_higher;
	always_comb
	begin
		any_higher = 1'b0;
		for (int i = 0; i < NUM_SRC; i++)
			if (req[i] && lvl[i] > win.level)
				any_higher = 1'b1;
	end

	property p_highest_wins;
		@(posedge clk) disable iff (!rst_n)
		win.valid |-> !any_higher && req[win.id];
	endproperty
	a_highest_wins: assert property (p_highest_wins)
		else $error("winner is not the highest pending level");

	property p_level_decode;
		@(posedge clk) disable iff (!rst_n)
		win.valid |-> win.level == {prio_msb[win.id], prio_lsb[win.id]};
	endproperty
	a_level_decode: assert property (p_level_decode)
		else $error("winner level does not match its priority bits");
endmodule // prio_select
`default_nettype wire

// >>> irq_arbiter.sv
// interrupt priority arbiter with apb registers and core sequencing
//
// How it works
// - eighteen sources, each with pending flag, vector
// - software-set pending flag vectors like hardware
// - level is msb:lsb, 00 lowest, 11 highest
// - low bits and high bits in separate registers
// - strictly higher level preempts running handler
// - highest-level handler is never preempted
// - reset puts all sources at level zero
// - equal levels resolved by fixed source order
// - pending requests sampled and decoded every clock
// - minimum response: detect one, call four clocks
// - after return, one instruction before next call
// - worst case eighteen clocks incl. return, divide
// - equal or lower waits for return plus one
// - on exit, highest pending request served next
`timescale 1ns/100ps
`default_nettype none
module irq_arbiter
	import irq_arb_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	input  wire logic [NUM_SRC-1:0] src_event,
	input  wire logic               instr_end,
	input  wire logic               return_from_handler,
	output logic                    long_subroutine_call,
	output logic                    call_active,
	output logic [ID_W-1:0]         handler_id,
	output logic [LVL_W-1:0]        handler_level,
	output logic [VEC_W-1:0]        handler_addr
);
	logic               global_en;
	logic [NUM_SRC-1:0] enable;
	logic [NUM_SRC-1:0] pending;
	logic [NUM_SRC-1:0] prio_lsb;
	logic [NUM_SRC-1:0] prio_msb;
	logic [3:0]         in_service;
	logic               return_from_handler_hold;
	logic [2:0]         call_cnt;
	arb_state_t         state;
	winner_t            win;
	logic [LVL_W-1:0]   top_level;
	logic               allowed;
	logic               wr_en;
	logic               rd_setup;

	// a write lands at the access edge, reads are staged in setup
	assign wr_en    = psel && penable && pwrite && pready;
	assign rd_setup = psel && !penable;

	// apb answer: ready in every access phase, error on unmapped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= rd_setup;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (rd_setup)
		begin
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			case (paddr)
				OFF_CTRL:       prdata[CTRL_GLOBAL_EN_BIT] <= global_en;
				OFF_ENABLE:     prdata[NUM_SRC-1:0] <= enable;
				OFF_PENDING:    prdata[NUM_SRC-1:0] <= pending;
				OFF_LSB_BASE:   prdata[7:0] <= prio_lsb[7:0];
				OFF_LSB_FIRST:  prdata[7:0] <= prio_lsb[15:8];
				OFF_LSB_SECOND: prdata[1:0] <= prio_lsb[17:16];
				OFF_MSB_BASE:   prdata[7:0] <= prio_msb[7:0];
				OFF_MSB_FIRST:  prdata[7:0] <= prio_msb[15:8];
				OFF_MSB_SECOND: prdata[1:0] <= prio_msb[17:16];
				OFF_STATUS:
				begin
					prdata[STAT_SVC_LSB +: 4]    <= in_service;
					prdata[STAT_HOLD_BIT]        <= return_from_handler_hold;
					prdata[STAT_STATE_LSB +: 2]  <= state;
					prdata[STAT_ID_LSB +: ID_W]  <= handler_id;
				end
				default:        pslverr <= 1'b1;
			endcase
		end
	end

	// control and enable registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			global_en <= RST_GLOBAL_EN;
			enable    <= RST_ENABLE;
		end
		else if (wr_en && paddr == OFF_CTRL)
			global_en <= pwdata[CTRL_GLOBAL_EN_BIT];
		else if (wr_en && paddr == OFF_ENABLE)
			enable <= pwdata[NUM_SRC-1:0];
	end

	// priority bits: low and high halves live in separate registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prio_lsb <= RST_PRIO;
			prio_msb <= RST_PRIO;
		end
		else if (wr_en)
		begin
			case (paddr)
				OFF_LSB_BASE:   prio_lsb[7:0]   <= pwdata[7:0];
				OFF_LSB_FIRST:  prio_lsb[15:8]  <= pwdata[7:0];
				OFF_LSB_SECOND: prio_lsb[17:16] <= pwdata[1:0];
				OFF_MSB_BASE:   prio_msb[7:0]   <= pwdata[7:0];
				OFF_MSB_FIRST:  prio_msb[15:8]  <= pwdata[7:0];
				OFF_MSB_SECOND: prio_msb[17:16] <= pwdata[1:0];
				default:        prio_lsb <= prio_lsb;
			endcase
		end
	end

	// pending flags: a source event beats a same-cycle software clear;
	// writing a one sets the flag exactly as hardware would
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pending <= RST_PENDING;
		else if (wr_en && paddr == OFF_PENDING)
			pending <= pwdata[NUM_SRC-1:0] | src_event;
		else
			pending <= pending | src_event;
	end

	// decode is combinational on the live flags, so every clock counts
	prio_select u_select (
		.req      (pending & enable & {NUM_SRC{global_en}}),
		.prio_lsb (prio_lsb),
		.prio_msb (prio_msb),
		.clk      (pclk),
		.rst_n    (presetn),
		.win      (win)
	);

	// level of the innermost running handler
	always_comb
	begin
		top_level = 2'b00;
		for (int l = 0; l < 4; l++)
			if (in_service[l])
				top_level = LVL_W'(l);
	end

	// a request may start only above the running level and never in
	// the return cycle; the call then waits for the next boundary, so
	// at least the one instruction after a return completes first
	assign allowed = win.valid && !return_from_handler &&
		(in_service == 4'h0 || win.level > top_level);

	// return hold flag: marks the instruction that follows a return
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			return_from_handler_hold <= 1'b0;
		else if (return_from_handler)
			return_from_handler_hold <= 1'b1;
		else if (instr_end)
			return_from_handler_hold <= 1'b0;
	end

	// sequencer: detect until the next instruction boundary, then the four-clock call
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state    <= ST_IDLE;
			call_cnt <= 3'h0;
		end
		else
		begin
			case (state)
				ST_IDLE:
					if (allowed)
						state <= ST_DETECT;
				ST_DETECT:
					if (!allowed)
						state <= ST_IDLE;
					else if (instr_end)
					begin
						state    <= ST_CALL;
						call_cnt <= 3'(CALL_CYCLES - 1);
					end
				ST_CALL:
					if (call_cnt == 3'h0)
						state <= ST_IDLE;
					else
						call_cnt <= call_cnt - 3'h1;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// latch the winner as the call begins; a later rival waits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			handler_id    <= '0;
			handler_level <= '0;
			handler_addr  <= VEC_BASE;
		end
		else if (state == ST_DETECT && allowed && instr_end)
		begin
			handler_id    <= win.id;
			handler_level <= win.level;
			handler_addr  <= VEC_W'(VEC_BASE +
				VEC_W'(win.id) * VEC_STRIDE);
		end
	end

	// call strobe and call window outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			long_subroutine_call <= 1'b0;
			call_active          <= 1'b0;
		end
		else
		begin
			long_subroutine_call <= state == ST_DETECT && allowed &&
				instr_end;
			call_active <= (state == ST_DETECT && allowed && instr_end) ||
				(state == ST_CALL && call_cnt != 3'h0);
		end
	end

	// in-service levels: one bit per level, top bit cleared on return
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			in_service <= 4'h0;
		else if (state == ST_DETECT && allowed && instr_end)
			in_service[win.level] <= 1'b1;
		else if (return_from_handler)
			in_service[top_level] <= 1'b0;
	end

	// checks
	property p_call_length;
		@(posedge pclk) disable iff (!presetn)
		long_subroutine_call |-> call_active[*4] ##1 !call_active;
	endproperty
	a_call_length: assert property (p_call_length)
		else $error("handler call does not last four clocks");

	property p_detect_to_call;
		@(posedge pclk) disable iff (!presetn)
		state == ST_DETECT && allowed && instr_end
			|=> long_subroutine_call && state == ST_CALL;
	endproperty
	a_detect_to_call: assert property (p_detect_to_call)
		else $error("call did not follow the detect clock");

	property p_after_return;
		@(posedge pclk) disable iff (!presetn)
		return_from_handler |=> return_from_handler_hold && !long_subroutine_call;
	endproperty
	a_after_return: assert property (p_after_return)
		else $error("call started before the following instruction");

	property p_top_locked;
		@(posedge pclk) disable iff (!presetn)
		in_service[3] && state == ST_IDLE |=> state != ST_DETECT;
	endproperty
	a_top_locked: assert property (p_top_locked)
		else $error("level three handler was preempted");

	property p_strict_preempt;
		@(posedge pclk) disable iff (!presetn)
		long_subroutine_call && $past(in_service) != 4'h0
			|-> handler_level > $past(top_level);
	endproperty
	a_strict_preempt: assert property (p_strict_preempt)
		else $error("preemption by equal or lower level");

	property p_sw_set;
		@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == OFF_PENDING
			|=> (pending & $past(pwdata[NUM_SRC-1:0])) ==
				$past(pwdata[NUM_SRC-1:0]);
	endproperty
	a_sw_set: assert property (p_sw_set)
		else $error("software write did not set pending flag");

	property p_event_wins;
		@(posedge pclk) disable iff (!presetn)
		|src_event |=> (pending & $past(src_event)) == $past(src_event);
	endproperty
	a_event_wins: assert property (p_event_wins)
		else $error("source event lost");

	property p_quick_start;
		@(posedge pclk) disable iff (!presetn)
		state == ST_IDLE && allowed |=> state == ST_DETECT;
	endproperty
	a_quick_start: assert property (p_quick_start)
		else $error("allowed request not detected next clock");

	c_top_call: cover property (@(posedge pclk) disable iff (!presetn)
		long_subroutine_call && handler_level == 2'b11);
	c_preempt: cover property (@(posedge pclk) disable iff (!presetn)
		long_subroutine_call && $past(in_service) != 4'h0);
	c_return_chain: cover property (@(posedge pclk) disable iff (!presetn)
		return_from_handler ##[1:20] long_subroutine_call);
endmodule // irq_arbiter
`default_nettype wire

// >>> core_model.sv
// behavioural processor core pacing instruction boundaries and returns
`timescale 1ns/100ps
`default_nettype none
module core_model
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] gap,
	input  wire logic       ret_go,
	output logic            instr_end,
	output logic            return_from_handler
);
	logic [3:0] cnt;
	// a return restarts the count so a whole instruction follows it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 4'h0;
			instr_end <= 1'b0;
			return_from_handler <= 1'b0;
		end
		else if (ret_go && !return_from_handler)
		begin
			cnt <= 4'h0;
			instr_end <= 1'b0;
			return_from_handler <= 1'b1;
		end
		else
		begin
			return_from_handler <= 1'b0;
			instr_end <= (cnt == gap - 4'h1);
			cnt <= (cnt == gap - 4'h1) ? 4'h0 : cnt + 4'h1;
		end
	end
endmodule // core_model
`default_nettype wire

// >>> tb.sv
// self-checking bench for the interrupt priority arbiter
`timescale 1ns/100ps
`default_nettype none
module tb;
	import irq_arb_pkg::*;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0]  paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic [NUM_SRC-1:0] src_event;
	logic               instr_end, return_from_handler, long_subroutine_call;
	logic               call_active, ret_go;
	logic [ID_W-1:0]    handler_id;
	logic [LVL_W-1:0]   handler_level;
	logic [VEC_W-1:0]   handler_addr;
	logic [3:0]         gap;
	int                 error_cnt, samples_checked, lat, cyc;
	irq_arbiter DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.src_event(src_event), .instr_end(instr_end),
		.return_from_handler(return_from_handler),
		.long_subroutine_call(long_subroutine_call),
		.call_active(call_active), .handler_id(handler_id),
		.handler_level(handler_level), .handler_addr(handler_addr));
	core_model core (.pclk(pclk), .presetn(presetn), .gap(gap),
		.ret_go(ret_go), .instr_end(instr_end),
		.return_from_handler(return_from_handler));
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// a hang is cut short well above the expected run length
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until pready is sampled high, then released
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic setup();
		wr(OFF_ENABLE, 32'h3FFFF);
		wr(OFF_CTRL, 32'h1);
	endtask
	task automatic wait_call(input int id, lvl, mx);
		lat = 0;
		do
		begin
			@(posedge pclk);
			#1;
			lat++;
		end
		while (long_subroutine_call !== 1'b1 && lat < mx);
		chk("call", 1, long_subroutine_call);
		chk("id", id, handler_id);
		chk("level", lvl, handler_level);
		chk("addr", VEC_BASE + VEC_STRIDE * id, handler_addr);
	endtask
	task automatic quiet(input int n);
		repeat (n)
		begin
			@(posedge pclk);
			#1;
			chk("no call", 0, long_subroutine_call);
		end
	endtask
	task automatic ret();
		@(posedge pclk);
		ret_go <= 1'b1;
		@(posedge pclk);
		ret_go <= 1'b0;
		#1;
		chk("return", 1, return_from_handler);
	endtask
	task automatic t_regs();
		rdc("msb base", OFF_MSB_BASE, 32'h0);
		rdc("msb first", OFF_MSB_FIRST, 32'h0);
		rdc("msb second", OFF_MSB_SECOND, 32'h0);
		rdc("lsb base", OFF_LSB_BASE, 32'h0);
		wr(OFF_LSB_FIRST, 32'hFF);
		wr(OFF_LSB_SECOND, 32'hF);
		rdc("lsb first", OFF_LSB_FIRST, 32'hFF);
		rdc("lsb second", OFF_LSB_SECOND, 32'h3);
		rdc("msb first", OFF_MSB_FIRST, 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		chk("slverr", 1, pslverr);
	endtask
	task automatic t_min();
		do_reset();
		setup();
		wr(OFF_PENDING, 32'h20);
		wait_call(5, 0, 8);
		chk("latency", 2, lat);
		repeat (3)
		begin
			@(posedge pclk);
			#1;
			chk("active", 1, call_active);
		end
		@(posedge pclk);
		#1;
		chk("active", 0, call_active);
	endtask
	// high bits stay zero here: the legacy two-level arrangement
	task automatic t_order();
		do_reset();
		wr(OFF_ENABLE, 32'h3FFFF);
		wr(OFF_LSB_BASE, 32'h40);
		wr(OFF_PENDING, 32'h58);
		wr(OFF_CTRL, 32'h1);
		wait_call(6, 1, 12);
		wr(OFF_PENDING, 32'h18);
		ret();
		wait_call(3, 0, 12);
	endtask
	// nesting runs with a slow core so boundaries are spread out
	task automatic t_nest();
		do_reset();
		gap <= 4'h4;
		wr(OFF_LSB_BASE, 32'h0D);
		wr(OFF_MSB_BASE, 32'h0E);
		setup();
		wr(OFF_PENDING, 32'h1);
		wait_call(0, 1, 12);
		@(posedge pclk);
		src_event <= 18'h20000;
		@(posedge pclk);
		src_event <= 18'h00000;
		quiet(12);
		wr(OFF_PENDING, 32'h20003);
		wait_call(1, 2, 12);
		wr(OFF_PENDING, 32'h20007);
		wait_call(2, 3, 12);
		wr(OFF_PENDING, 32'h2000F);
		quiet(12);
		rdc("status", OFF_STATUS, 32'h0002000E);
		wr(OFF_PENDING, 32'h20008);
		ret();
		quiet(3);
		wait_call(3, 3, 18);
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		src_event = 18'h00000;
		ret_go = 1'b0;
		gap = 4'h1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_min();
		t_order();
		t_nest();
		close_out();
	end
endmodule // tb
`default_nettype wire
